// ---- hdl/fp_exec_pkg.sv ----
/*
  Shared constants and types of the floating point execution unit.
  Assumes requests carry register values already read by the integer pipeline.
*/
package fp_exec_pkg;
  localparam int          SGL_EW         = 8;
  localparam int          SGL_MW         = 23;
  localparam int          DBL_EW         = 11;
  localparam int          DBL_MW         = 52;
  localparam int          CC_COUNT       = 8;
  localparam int          ITER_BITS      = 53;
  localparam logic [7:0]  CC_RESET       = 8'h00;
  localparam logic [12:0] SGL_TO_DBL_EXP = 13'h0380;
  localparam logic [12:0] DBL_BIAS       = 13'h03FF;
  localparam logic [12:0] RECIP_EXP_BASE = 13'h07FD;
  localparam logic [12:0] DBL_EXP_MAX    = 13'h07FF;
  localparam logic [12:0] SGL_EXP_MAX    = 13'h00FF;
  localparam logic [31:0] SGL_ONE        = 32'h3F80_0000;
  localparam logic [63:0] DBL_ONE        = 64'h3FF0_0000_0000_0000;
  localparam logic [63:0] DBL_QNAN       = 64'h7FF8_0000_0000_0000;
  localparam logic [63:0] DBL_INF        = 64'h7FF0_0000_0000_0000;
  localparam logic [63:0] WORD_SAT       = 64'h0000_0000_7FFF_FFFF;
  localparam logic [63:0] LONG_SAT       = 64'h7FFF_FFFF_FFFF_FFFF;
  localparam logic [63:0] DWORD_ADDR_MSK = 64'hFFFF_FFFF_FFFF_FFF8;
  localparam logic [105:0] RECIP_NUM     = {1'b1, 105'h0};

  typedef enum logic [1:0] {
    fmt_single = 2'h0,
    fmt_double = 2'h1,
    fmt_word   = 2'h2,
    fmt_long   = 2'h3
  } fmt_t;

  typedef enum logic [4:0] {
    op_fp_move_if_gpr_nonzero        = 5'h00,
    op_fp_move_if_gpr_zero           = 5'h01,
    op_fp_move_if_cond_true          = 5'h02,
    op_fp_fused_mul_add              = 5'h03,
    op_fp_fused_mul_sub              = 5'h04,
    op_fp_neg_fused_mul_add          = 5'h05,
    op_fp_neg_fused_mul_sub          = 5'h06,
    op_fp_multiply                   = 5'h07,
    op_fp_subtract                   = 5'h08,
    op_fp_negate                     = 5'h09,
    op_fp_reciprocal                 = 5'h0A,
    op_fp_recip_sqrt                 = 5'h0B,
    op_fp_sqrt                       = 5'h0C,
    op_fp_round_to_long              = 5'h0D,
    op_fp_round_to_word              = 5'h0E,
    op_fp_trunc_to_long              = 5'h0F,
    op_fp_trunc_to_word              = 5'h10,
    op_gpr_to_fpr_word_move          = 5'h11,
    op_fp_compare                    = 5'h12,
    op_fp_store_dword_offset         = 5'h13,
    op_fp_store_word_offset          = 5'h14,
    op_fp_store_dword_indexed        = 5'h15,
    op_fp_store_word_indexed         = 5'h16,
    op_fp_store_dword_indexed_unaligned = 5'h17
  } op_t;

  typedef struct packed {
    op_t         op;
    fmt_t        fmt;
    logic [4:0]  fp_destination;
    logic [63:0] fp_source_a;
    logic [63:0] fp_source_b;
    logic [63:0] fp_source_addend;
    logic [63:0] gpr_operand;
    logic [63:0] base;
    logic [63:0] index;
    logic [15:0] offset;
    logic [2:0]  cc_sel;
    logic [2:0]  cmp_cond;
  } req_t;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic        illegal;
    logic [4:0]  fp_destination;
    logic [63:0] data;
  } res_t;

  typedef struct packed {
    logic        valid;
    logic        dword;
    logic [63:0] addr;
    logic [63:0] data;
  } store_t;
endpackage : fp_exec_pkg

// ---- hdl/fp_exec_unit.sv ----
/*
  Floating point execution unit: conditional moves, fused multiply families, reciprocal,
  square roots, fixed point conversion, compare and floating stores.
  Assumes the integer pipeline supplies register values and consumes results and store requests.
*/
`timescale 1ns/1ps
`default_nettype none
module fp_exec_unit import fp_exec_pkg::*; (
  input  wire logic          REF_CLK_I,
  input  wire logic          RESETN_I,
  input  wire logic          REQ_VALID_I,
  input  wire req_t          REQ_I,
  output var  logic          REQ_READY_O,
  output var  res_t          RES_O,
  output var  store_t        STORE_O,
  output var  logic [7:0]    COND_CODES_O
);
  typedef enum logic [1:0] {
    st_idle    = 2'h0,
    st_iterate = 2'h1,
    st_finish  = 2'h2
  } it_state_t;

  function automatic logic [63:0] widen(input logic [31:0] v);
    logic [12:0] e;
    e = {5'h0, v[30:23]} + SGL_TO_DBL_EXP;
    if (v[30:23] == 8'h00)      widen = {v[31], 63'h0};
    else if (v[30:23] == 8'hFF) widen = {v[31], 11'h7FF, v[22:0], 29'h0};
    else                        widen = {v[31], e[10:0], v[22:0], 29'h0};
  endfunction : widen

  function automatic logic [31:0] narrow(input logic [63:0] d);
    logic [12:0] e;
    e = {2'h0, d[62:52]} - SGL_TO_DBL_EXP;
    if (d[62:52] == 11'h7FF)             narrow = {d[63], 8'hFF, d[51:29]};
    else if (d[62:52] == 11'h000 || $signed(e) <= 0) narrow = {d[63], 31'h0};
    else if ($signed(e) >= $signed(SGL_EXP_MAX)) narrow = {d[63], 8'hFF, 23'h0};
    else                                 narrow = {d[63], e[7:0], d[51:29]};
  endfunction : narrow

  logic              take, is_sgl, fmt_ok, neg_c, neg_res, to_word, nearest, is_nan_a;
  logic              un, eq, lt, cmp_res, res_write, res_illegal, it_start, dzero;
  logic [63:0]       fb, fc, fma_sgl, fma_dbl, fix_sgl, fix_dbl, da, db, res_data, trial;
  logic [105:0]      tprod;
  logic [12:0]       ea;
  it_state_t         it_state_q;
  logic              ready_q, it_sgl_q, it_rsqrt_q, it_sqrt_q;
  logic [4:0]        it_dest_q;
  logic [52:0]       it_m_q, it_root_q;
  logic [5:0]        it_bit_q;
  logic [12:0]       it_e_q;
  logic [105:0]      it_bound_q;
  logic [63:0]       it_spec_q, it_out;
  logic              it_special_q;
  logic [7:0]        cc_q;
  res_t              res_q;
  store_t            store_q;

  assign take   = REQ_VALID_I & ready_q;
  assign is_sgl = (REQ_I.fmt == fmt_single);
  assign fmt_ok = (REQ_I.fmt == fmt_single) | (REQ_I.fmt == fmt_double);
  assign da     = is_sgl ? widen(REQ_I.fp_source_a[31:0]) : REQ_I.fp_source_a;
  assign db     = is_sgl ? widen(REQ_I.fp_source_b[31:0]) : REQ_I.fp_source_b;
  assign ea     = {2'h0, da[62:52]};

  // operand steering for the shared fused datapath
  always_comb begin
    fb      = REQ_I.fp_source_b;
    fc      = REQ_I.fp_source_addend;
    neg_c   = 1'b0;
    neg_res = 1'b0;
    case (REQ_I.op)
      op_fp_fused_mul_sub:     neg_c = 1'b1;
      op_fp_neg_fused_mul_add: neg_res = 1'b1;
      op_fp_neg_fused_mul_sub: begin
        neg_c   = 1'b1;
        neg_res = 1'b1;
      end
      op_fp_multiply:          fc = 64'h0;
      op_fp_subtract: begin
        fb    = is_sgl ? {32'h0, SGL_ONE} : DBL_ONE;
        fc    = REQ_I.fp_source_b;
        neg_c = 1'b1;
      end
      default: begin
        neg_c = 1'b0;
      end
    endcase
  end

  fp_fma #(.EW(SGL_EW), .MW(SGL_MW)) u_fma_sgl (
    .a_i       (REQ_I.fp_source_a[31:0]),
    .b_i       (fb[31:0]),
    .c_i       (fc[31:0]),
    .neg_c_i   (neg_c),
    .neg_res_i (neg_res),
    .res_o     (fma_sgl[31:0])
  );
  assign fma_sgl[63:32] = 32'h0;

  fp_fma #(.EW(DBL_EW), .MW(DBL_MW)) u_fma_dbl (
    .a_i       (REQ_I.fp_source_a),
    .b_i       (fb),
    .c_i       (fc),
    .neg_c_i   (neg_c),
    .neg_res_i (neg_res),
    .res_o     (fma_dbl)
  );

  assign to_word = (REQ_I.op == op_fp_round_to_word) | (REQ_I.op == op_fp_trunc_to_word);
  assign nearest = (REQ_I.op == op_fp_round_to_word) | (REQ_I.op == op_fp_round_to_long);

  fp_to_fixed #(.EW(SGL_EW), .MW(SGL_MW)) u_fix_sgl (
    .val_i     (REQ_I.fp_source_a[31:0]),
    .to_word_i (to_word),
    .nearest_i (nearest),
    .res_o     (fix_sgl)
  );

  fp_to_fixed #(.EW(DBL_EW), .MW(DBL_MW)) u_fix_dbl (
    .val_i     (REQ_I.fp_source_a),
    .to_word_i (to_word),
    .nearest_i (nearest),
    .res_o     (fix_dbl)
  );

  // compare: unordered, equal, less than, done on widened operands
  always_comb begin
    is_nan_a = (da[62:52] == 11'h7FF) & (da[51:0] != 52'h0);
    un       = is_nan_a | ((db[62:52] == 11'h7FF) & (db[51:0] != 52'h0));
    dzero    = (da[62:0] == 63'h0) & (db[62:0] == 63'h0);
    eq       = ~un & ((da == db) | dzero);
    if (da[63] != db[63]) lt = ~un & da[63] & ~dzero;
    else if (da[63])      lt = ~un & (da[62:0] > db[62:0]);
    else                  lt = ~un & (da[62:0] < db[62:0]);
    cmp_res  = (un & REQ_I.cmp_cond[0]) | (eq & REQ_I.cmp_cond[1]) | (lt & REQ_I.cmp_cond[2]);
  end

  // single cycle results
  always_comb begin
    res_data    = REQ_I.fp_source_a;
    res_write   = 1'b0;
    res_illegal = 1'b0;
    it_start    = 1'b0;
    case (REQ_I.op)
      op_fp_move_if_gpr_nonzero: res_write = (REQ_I.gpr_operand != 64'h0);
      op_fp_move_if_gpr_zero:    res_write = (REQ_I.gpr_operand == 64'h0);
      op_fp_move_if_cond_true:   res_write = cc_q[REQ_I.cc_sel];
      op_fp_fused_mul_add, op_fp_fused_mul_sub, op_fp_neg_fused_mul_add,
      op_fp_neg_fused_mul_sub, op_fp_multiply, op_fp_subtract: begin
        res_data  = is_sgl ? fma_sgl : fma_dbl;
        res_write = 1'b1;
      end
      op_fp_negate: begin
        res_data  = is_sgl ? {32'h0, ~REQ_I.fp_source_a[31], REQ_I.fp_source_a[30:0]}
                           : {~REQ_I.fp_source_a[63], REQ_I.fp_source_a[62:0]};
        res_write = 1'b1;
      end
      op_fp_round_to_long, op_fp_round_to_word, op_fp_trunc_to_long, op_fp_trunc_to_word: begin
        res_data  = is_sgl ? fix_sgl : fix_dbl;
        res_write = 1'b1;
      end
      op_gpr_to_fpr_word_move: begin
        res_data  = {32'h0, REQ_I.gpr_operand[31:0]};
        res_write = 1'b1;
      end
      op_fp_reciprocal, op_fp_recip_sqrt, op_fp_sqrt: it_start = fmt_ok;
      default: res_write = 1'b0;
    endcase
    if (!fmt_ok && REQ_I.op != op_gpr_to_fpr_word_move && REQ_I.op < op_fp_store_dword_offset) begin
      res_write   = 1'b0;
      res_illegal = 1'b1;
    end
  end

  always_ff @(posedge REF_CLK_I) begin
    if (!RESETN_I) begin
      cc_q <= CC_RESET;
    end else if (take && REQ_I.op == op_fp_compare && fmt_ok) begin
      cc_q[REQ_I.cc_sel] <= cmp_res;
    end
  end

  always_ff @(posedge REF_CLK_I) begin
    if (!RESETN_I) begin
      store_q <= '0;
    end else begin
      store_q.valid <= take & (REQ_I.op >= op_fp_store_dword_offset);
      store_q.dword <= (REQ_I.op == op_fp_store_dword_offset) | (REQ_I.op == op_fp_store_dword_indexed)
                     | (REQ_I.op == op_fp_store_dword_indexed_unaligned);
      case (REQ_I.op)
        op_fp_store_dword_offset, op_fp_store_word_offset: begin
          store_q.addr <= REQ_I.base + {{48{REQ_I.offset[15]}}, REQ_I.offset};
          store_q.data <= REQ_I.fp_source_b;
        end
        op_fp_store_dword_indexed_unaligned: begin
          store_q.addr <= (REQ_I.base + REQ_I.index) & DWORD_ADDR_MSK;
          store_q.data <= REQ_I.fp_source_a;
        end
        default: begin
          store_q.addr <= REQ_I.base + REQ_I.index;
          store_q.data <= REQ_I.fp_source_a;
        end
      endcase
    end
  end

  // one trial bit per cycle; sqrt squares the trial, reciprocal scales the divisor
  assign trial = {11'h0, it_root_q | (53'h1 << it_bit_q)};
  assign tprod = it_sqrt_q ? (106'(trial[52:0]) * 106'(trial[52:0])) : (106'(trial[52:0]) * 106'(it_m_q));

  // a mantissa of exactly one overflows the 53-bit quotient; give the exact power of two
  always_comb begin
    if (it_special_q)                        it_out = it_spec_q;
    else if (!it_sqrt_q && (&it_root_q))     it_out = {it_spec_q[63], it_e_q[10:0] + 11'h001, 52'h0};
    else if ($signed(it_e_q) <= 0)           it_out = {it_spec_q[63], 63'h0};
    else if ($signed(it_e_q) >= $signed(DBL_EXP_MAX)) it_out = {it_spec_q[63], DBL_INF[62:0]};
    else                                     it_out = {it_spec_q[63], it_e_q[10:0], it_root_q[51:0]};
  end

  always_ff @(posedge REF_CLK_I) begin
    if (!RESETN_I) begin
      it_state_q   <= st_idle;
      ready_q      <= 1'b1;
      it_sgl_q     <= 1'b0;
      it_rsqrt_q   <= 1'b0;
      it_sqrt_q    <= 1'b0;
      it_dest_q    <= 5'h00;
      it_m_q       <= 53'h0;
      it_root_q    <= 53'h0;
      it_bit_q     <= 6'h00;
      it_e_q       <= 13'h0000;
      it_bound_q   <= 106'h0;
      it_spec_q    <= 64'h0;
      it_special_q <= 1'b0;
    end else begin
      case (it_state_q)
        st_idle: if (take && it_start) begin
          ready_q      <= 1'b0;
          it_sgl_q     <= is_sgl;
          it_dest_q    <= REQ_I.fp_destination;
          it_rsqrt_q   <= (REQ_I.op == op_fp_recip_sqrt);
          it_sqrt_q    <= (REQ_I.op != op_fp_reciprocal);
          it_m_q       <= {1'b1, da[51:0]};
          it_root_q    <= 53'h0;
          it_bit_q     <= 6'(ITER_BITS - 1);
          it_special_q <= 1'b1;
          it_state_q   <= st_finish;
          if (is_nan_a || (da[63] && ea != 13'h0 && REQ_I.op != op_fp_reciprocal)) it_spec_q <= DBL_QNAN;
          else if (ea == 13'h0)
            it_spec_q <= (REQ_I.op == op_fp_sqrt) ? da : {da[63], DBL_INF[62:0]};
          else if (ea == DBL_EXP_MAX)
            it_spec_q <= (REQ_I.op == op_fp_sqrt) ? DBL_INF : {da[63], 63'h0};
          else begin
            it_special_q <= 1'b0;
            it_state_q   <= st_iterate;
            it_spec_q    <= {da[63], 63'h0};
            if (REQ_I.op == op_fp_reciprocal) begin
              it_e_q     <= RECIP_EXP_BASE - ea;
              it_bound_q <= RECIP_NUM;
            end else begin
              it_e_q     <= 13'($signed(ea - DBL_BIAS) >>> 1) + DBL_BIAS;
              // even biased exponent is an odd power: radicand doubled so the halved exponent is whole
              it_bound_q <= ea[0] ? {1'b0, 1'b1, da[51:0], 52'h0}
                                  : {1'b1, da[51:0], 53'h0};
            end
          end
        end
        st_iterate: begin
          if (tprod <= it_bound_q) it_root_q <= trial[52:0];
          if (it_bit_q == 6'h00) begin
            it_state_q <= st_finish;
          end else begin
            it_bit_q <= it_bit_q - 6'h01;
          end
        end
        st_finish: begin
          if (it_rsqrt_q && !it_special_q) begin
            it_rsqrt_q <= 1'b0;
            it_sqrt_q  <= 1'b0;
            it_m_q     <= it_root_q;
            it_root_q  <= 53'h0;
            it_bit_q   <= 6'(ITER_BITS - 1);
            it_e_q     <= RECIP_EXP_BASE - it_e_q;
            it_bound_q <= RECIP_NUM;
            it_state_q <= st_iterate;
          end else begin
            ready_q    <= 1'b1;
            it_state_q <= st_idle;
          end
        end
        default: it_state_q <= st_idle;
      endcase
    end
  end

  always_ff @(posedge REF_CLK_I) begin
    if (!RESETN_I) begin
      res_q <= '0;
    end else if (it_state_q == st_finish && !(it_rsqrt_q && !it_special_q)) begin
      res_q.valid          <= 1'b1;
      res_q.write          <= 1'b1;
      res_q.illegal        <= 1'b0;
      res_q.fp_destination <= it_dest_q;
      res_q.data           <= it_sgl_q ? {32'h0, narrow(it_out)} : it_out;
    end else begin
      res_q.valid          <= take & ~it_start & (REQ_I.op < op_fp_store_dword_offset);
      res_q.write          <= take & res_write;
      res_q.illegal        <= take & res_illegal;
      res_q.fp_destination <= REQ_I.fp_destination;
      res_q.data           <= res_data;
    end
  end

  assign REQ_READY_O  = ready_q;
  assign RES_O        = res_q;
  assign STORE_O      = store_q;
  assign COND_CODES_O = cc_q;
endmodule : fp_exec_unit
`default_nettype wire

// ---- hdl/fp_fma.sv ----
/*
  Combinational fused multiply-add for one IEEE format: a*b + (+/-c), result optionally negated.
  Assumes no denormals (flushed to zero) and that its caller registers the result.
*/
`timescale 1ns/1ps
`default_nettype none
module fp_fma #(
  parameter int EW = 11,
  parameter int MW = 52
) (
  input  wire logic [EW+MW:0] a_i,
  input  wire logic [EW+MW:0] b_i,
  input  wire logic [EW+MW:0] c_i,
  input  wire logic           neg_c_i,
  input  wire logic           neg_res_i,
  output logic      [EW+MW:0] res_o
);
  localparam int PW = 2 * MW + 2;
  localparam int G  = 3;
  localparam int XW = PW + G + 1;
  localparam int SW = EW + 3;
  localparam logic [EW-1:0] EMAX = '1;
  localparam logic [SW-1:0] BIAS = SW'({(EW-1){1'b1}});

  logic [MW:0]          ma, mb, mc, rnd;
  logic [PW-1:0]        prod;
  logic signed [SW-1:0] ep, ec, eb, er;
  logic [XW-1:0]        xp, xc, big, sml, sum, norm;
  logic                 sp, sc, sb, ss, sr, spec;
  int                   top;

  always_comb begin
    top  = 0;
    ma   = (a_i[EW+MW-1:MW] == '0) ? '0 : {1'b1, a_i[MW-1:0]};
    mb   = (b_i[EW+MW-1:MW] == '0) ? '0 : {1'b1, b_i[MW-1:0]};
    mc   = (c_i[EW+MW-1:MW] == '0) ? '0 : {1'b1, c_i[MW-1:0]};
    spec = (a_i[EW+MW-1:MW] == EMAX) | (b_i[EW+MW-1:MW] == EMAX) | (c_i[EW+MW-1:MW] == EMAX);
    prod = PW'(ma) * PW'(mb);
    sp   = a_i[EW+MW] ^ b_i[EW+MW];
    sc   = c_i[EW+MW] ^ neg_c_i;
    ep   = SW'(a_i[EW+MW-1:MW]) + SW'(b_i[EW+MW-1:MW]) - BIAS + SW'(1);
    ec   = SW'(c_i[EW+MW-1:MW]);
    if (prod == '0) ep = ec;
    if (mc == '0) ec = ep;
    xp = {1'b0, prod, G'(0)};
    xc = {1'b0, mc, (MW + 1 + G)'(0)};
    // the addend sits at the product's top so one shifter aligns both ways
    if (ep >= ec) begin
      big = xp; sb = sp; sml = xc >> (ep - ec); ss = sc; eb = ep;
    end else begin
      big = xc; sb = sc; sml = xp >> (ec - ep); ss = sp; eb = ec;
    end
    if (sb == ss) begin
      sum = big + sml; sr = sb;
    end else if (big >= sml) begin
      sum = big - sml; sr = sb;
    end else begin
      sum = sml - big; sr = ss;
    end
    for (int i = 0; i < XW; i++) begin
      if (sum[i]) top = i;
    end
    norm = sum << (XW - 1 - top);
    er   = eb + SW'(top) - SW'(PW - 1 + G);
    // round to nearest, ties away; sticky beyond the guard bits is dropped
    rnd  = {1'b0, norm[XW-2 -: MW]} + (MW+1)'(norm[XW-2-MW]);
    if (rnd[MW]) er = er + SW'(1);
    if (spec)                   res_o = {1'b0, EMAX, 1'b1, (MW-1)'(0)};
    else if (sum == '0)         res_o = {neg_res_i, (EW+MW)'(0)};
    else if (er <= 0)           res_o = {sr ^ neg_res_i, (EW+MW)'(0)};
    else if (er >= SW'(EMAX))   res_o = {sr ^ neg_res_i, EMAX, MW'(0)};
    else                        res_o = {sr ^ neg_res_i, er[EW-1:0], rnd[MW-1:0]};
  end
endmodule : fp_fma
`default_nettype wire

// ---- hdl/fp_to_fixed.sv ----
/*
  Combinational conversion of one IEEE format to a 32- or 64-bit signed integer.
  Assumes the caller picks the rounding and width; out-of-range gives the largest positive value.
*/
`timescale 1ns/1ps
`default_nettype none
module fp_to_fixed import fp_exec_pkg::*; #(
  parameter int EW = 11,
  parameter int MW = 52
) (
  input  wire logic [EW+MW:0] val_i,
  input  wire logic           to_word_i,
  input  wire logic           nearest_i,
  output logic      [63:0]    res_o
);
  localparam int W  = MW + 1 + 128;
  localparam int SW = EW + 2;
  localparam logic [SW-1:0] BIAS = SW'({(EW-1){1'b1}});
  localparam logic [EW-1:0] EMAX = '1;

  logic signed [SW-1:0] su;
  logic [W-1:0]         sv;
  logic [63:0]          mag, sat, lim, sres;
  logic                 up;

  always_comb begin
    su   = SW'(val_i[EW+MW-1:MW]) - BIAS;
    sat  = to_word_i ? WORD_SAT : LONG_SAT;
    lim  = to_word_i ? 64'h0000_0000_8000_0000 : 64'h8000_0000_0000_0000;
    sv   = '0;
    up   = 1'b0;
    mag  = '0;
    sres = '0;
    if (val_i[EW+MW-1:MW] == EMAX || su >= SW'(to_word_i ? 31 : 63)) begin
      res_o = sat;
    end else begin
      if (su >= -SW'(2)) begin
        sv  = W'({1'b1, val_i[MW-1:0]}) << (su - SW'(MW) + SW'(64));
        up  = nearest_i & sv[63] & ((|sv[62:0]) | sv[64]);
        mag = sv[127:64] + 64'(up);
      end
      sres  = val_i[EW+MW] ? (64'h0 - mag) : mag;
      if (mag >= lim) res_o = sat;
      else            res_o = to_word_i ? {32'h0, sres[31:0]} : sres;
    end
  end
endmodule : fp_to_fixed
`default_nettype wire

// ---- tb/fp_exec_unit_chk.sv ----
/* port checker of the unit, bound below; assumes a synchronous active-low reset */
`timescale 1ns/1ps
`default_nettype none
module fp_exec_unit_chk import fp_exec_pkg::*; (
  input wire logic       REF_CLK_I,
  input wire logic       RESETN_I,
  input wire logic       REQ_VALID_I,
  input wire req_t       REQ_I,
  input wire logic       REQ_READY_O,
  input wire res_t       RES_O,
  input wire store_t     STORE_O,
  input wire logic [7:0] COND_CODES_O
);
  default clocking @(posedge REF_CLK_I); endclocking
  default disable iff (!RESETN_I);
  wire logic        tk = REQ_VALID_I & REQ_READY_O;
  wire logic        sd = !REQ_I.fmt[1];
  wire op_t         o  = REQ_I.op;
  wire logic        g  = REQ_I.gpr_operand != 64'h0;
  wire logic [63:0] bi = REQ_I.base + REQ_I.index;
  nz_move_a: assert property (tk && o == op_fp_move_if_gpr_nonzero && sd && g
    |=> RES_O.valid && RES_O.write) else $error("move skipped");
  z_move_a: assert property (tk && o == op_fp_move_if_gpr_zero && g
    |=> RES_O.valid && !RES_O.write) else $error("move written");
  cc_move_a: assert property (tk && o == op_fp_move_if_cond_true && sd
    |=> RES_O.write == $past(COND_CODES_O[REQ_I.cc_sel])) else $error("cond move");
  off_store_a: assert property (tk && o == op_fp_store_dword_offset |=> STORE_O.valid
    && STORE_O.addr == $past(REQ_I.base + {{48{REQ_I.offset[15]}}, REQ_I.offset})) else $error("offset addr");
  idx_store_a: assert property (tk && o == op_fp_store_word_indexed
    |=> STORE_O.valid && !STORE_O.dword && STORE_O.addr == $past(bi)) else $error("index addr");
  unal_store_a: assert property (tk && o == op_fp_store_dword_indexed_unaligned
    |=> STORE_O.addr == ($past(bi) & DWORD_ADDR_MSK)) else $error("unaligned addr");
  bad_fmt_a: assert property (tk && o == op_fp_multiply && !sd |=> RES_O.illegal && !RES_O.write)
    else $error("format taken");
  root_busy_a: assert property (tk && o == op_fp_sqrt && sd |=> !REQ_READY_O ##[1:110] RES_O.valid)
    else $error("root timing");
endmodule : fp_exec_unit_chk
bind fp_exec_unit fp_exec_unit_chk chk (.REF_CLK_I, .RESETN_I, .REQ_VALID_I, .REQ_I, .REQ_READY_O, .RES_O,
  .STORE_O, .COND_CODES_O);
`default_nettype wire

// ---- tb/fp_exec_unit_tb.sv ----
/* bench of the unit: scenario tasks via the pipeline model; assumes the model and checker */
`timescale 1ns/1ps
`default_nettype none
module fp_exec_unit_tb import fp_exec_pkg::*; ;
  logic   clk = 1'b0, rstn = 1'b0, go = 1'b0, rdy, vld;
  req_t   r, dq, rq = '0;
  res_t   ro;
  store_t so;
  logic [7:0] cc;
  int     bad_count, tests_run, n;
  fp_pipe_model PM (.clk_i(clk), .go_i(go), .req_i(rq), .ready_i(rdy), .valid_o(vld), .req_o(dq));
  fp_exec_unit DUT (.REF_CLK_I(clk), .RESETN_I(rstn), .REQ_VALID_I(vld), .REQ_I(dq), .REQ_READY_O(rdy),
    .RES_O(ro), .STORE_O(so), .COND_CODES_O(cc));
  initial forever #5 clk = ~clk;
  task print_verdict();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : print_verdict
  task cmp(input string s, input logic [63:0] e, g);
    tests_run++;
    if (g !== e) bad_count++;
    if (g !== e) $display("[ERR] %s expected %h seen %h", s, e, g);
  endtask : cmp
  // 200 cycles covers the slowest iterative op
  task run();
    n = 0;
    @(posedge clk);
    go <= 1'b1;
    rq <= r;
    @(posedge clk);
    go <= 1'b0;
    do @(negedge clk); while (!(ro.valid | so.valid) && ++n < 200);
    bad_count += int'(n == 200);
    if (n == 200) print_verdict();
  endtask : run
  task automatic t_arith();
    op_t o [14] = '{op_fp_fused_mul_add, op_fp_fused_mul_sub, op_fp_neg_fused_mul_add, op_fp_neg_fused_mul_sub,
      op_fp_reciprocal, op_fp_recip_sqrt, op_fp_sqrt, op_fp_round_to_word, op_fp_trunc_to_long, op_fp_multiply,
      op_fp_subtract, op_fp_negate, op_fp_round_to_long, op_fp_trunc_to_word};
    logic [15:0] a [14] = '{16'h4000, 16'h4000, 16'h4000, 16'h4000, 16'h4000, 16'h4010, 16'h4010,
      16'h4004, 16'hC004, 16'h4000, 16'h4000, 16'h4000, 16'h400C, 16'h4004};
    logic [63:0] e [14] = '{{16'h401C, 48'h0}, {16'h4014, 48'h0}, {16'hC01C, 48'h0}, {16'hC014, 48'h0},
      {16'h3FE0, 48'h0}, {16'h3FE0, 48'h0}, {16'h4000, 48'h0}, 64'h2, 64'hFFFF_FFFF_FFFF_FFFE,
      {16'h4018, 48'h0}, {16'hBFF0, 48'h0}, {16'hC000, 48'h0}, 64'h4, 64'h2};
    r = '0;
    r.fmt = fmt_double;
    r.fp_destination = 5'h0D;
    r.fp_source_b = {16'h4008, 48'h0};
    r.fp_source_addend = {16'h3FF0, 48'h0};
    for (int i = 0; i < 14; i++) begin
      r.op = o[i];
      r.fp_source_a = {a[i], 48'h0};
      run();
      cmp("arith", e[i], ro.data);
      cmp("dest", 64'hD, ro.fp_destination);
    end
    r.fmt = fmt_single;
    r.op = op_fp_fused_mul_add;
    r.fp_source_a = 64'h4000_0000;
    r.fp_source_b = 64'h4040_0000;
    r.fp_source_addend = 64'h3F80_0000;
    run();
    cmp("sgl fma", 64'h40E0_0000, ro.data);
    r.op = op_fp_sqrt;
    r.fp_source_a = 64'h4080_0000;
    run();
    cmp("sgl root", 64'h4000_0000, ro.data);
    r.op = op_fp_multiply;
    r.fmt = fmt_word;
    run();
    cmp("illegal", 64'h1, ro.illegal);
  endtask : t_arith
  task t_cond();
    r = '0;
    r.fmt = fmt_double;
    r.fp_source_a = {16'h3FF0, 48'h0};
    r.fp_source_b = r.fp_source_a;
    r.gpr_operand = 64'h5;
    r.cmp_cond = 3'h2;
    r.cc_sel = 3'h3;
    r.op = op_fp_move_if_gpr_nonzero;
    run();
    cmp("nz move", {16'h3FF0, 48'h0}, ro.data);
    r.op = op_fp_move_if_gpr_zero;
    run();
    cmp("z move", 64'h0, ro.write);
    r.op = op_fp_compare;
    run();
    cmp("cond", 64'h8, cc);
    r.op = op_fp_move_if_cond_true;
    run();
    cmp("cc move", 64'h1, ro.write);
    r.op = op_gpr_to_fpr_word_move;
    r.gpr_operand = 64'hA5A5_0000_0000_0005;
    run();
    cmp("word move", 64'h5, ro.data);
  endtask : t_cond
  task t_store();
    r = '0;
    r.base = 64'h1000;
    r.offset = 16'hFFF8;
    r.index = 64'h27;
    r.fp_source_b = 64'h22;
    r.op = op_fp_store_dword_offset;
    run();
    cmp("off addr", 64'hFF8, so.addr);
    cmp("off data", 64'h22, so.data);
    cmp("off dword", 64'h1, so.dword);
    r.op = op_fp_store_word_indexed;
    run();
    cmp("idx addr", 64'h1027, so.addr);
    r.op = op_fp_store_dword_indexed_unaligned;
    run();
    cmp("unal addr", 64'h1020, so.addr);
  endtask : t_store
  initial begin
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    t_arith();
    t_cond();
    t_store();
    print_verdict();
  end
endmodule : fp_exec_unit_tb
`default_nettype wire

// ---- tb/fp_pipe_model.sv ----
/* integer pipeline side: presents one request, holds it until taken */
`timescale 1ns/1ps
`default_nettype none
module fp_pipe_model import fp_exec_pkg::*; (
  input  wire logic clk_i,
  input  wire logic go_i,
  input  wire req_t req_i,
  input  wire logic ready_i,
  output var  logic valid_o = 1'b0,
  output var  req_t req_o = '0
);
  // request never changes before the taking edge
  always @(posedge clk_i) begin
    if (go_i) begin
      valid_o <= 1'b1;
      req_o   <= req_i;
    end else if (ready_i) begin
      valid_o <= 1'b0;
    end
  end
endmodule : fp_pipe_model
`default_nettype wire
